// file: src/sua_uart.sv
// async uart function of the shared serial interface module
`timescale 1ns/100ps
//
// Contract
// - eight or nine data bits per character
// - even, odd or no parity, generate and check
// - one or two stop bits sent
// - baud from eight-bit divisor register
// - parity, framing, noise, overrun flags separately
// - address mode: interrupt only if last bit one
// - received characters held in two-entry buffer
// - receive pin activity wakes device when enabled
// - interrupts: tx empty, tx idle, rx full, overrun, address
// - all causes merged onto one shared vector
// - independent transmit and receive enables
// - enabled: drive transmit pin, drop its pull-up
// - disabled: pins float, pull-up left to port
// - single-wire select bit zero of third control
// - single wire: rx when rx on, else tx
// - both enables in single wire: receiver wins
// - single wire: transmit also on dedicated pin
// - data write to holding register, then shifted lsb first
// - rx shifted lsb first, then to buffer
// - shift registers have no address
// - one data address: write tx, read oldest rx
// - uart registers usable only with mode select set
module sua_uart (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire sua_pkg::sua_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic serial_in_shared_pin_in,
  output logic serial_in_shared_pin_out,
  output logic serial_in_shared_pin_oe,
  output logic serial_out_pin,
  output logic serial_out_pin_oe,
  output logic tx_pullup_disable,
  output logic usim_irq,
  output logic pin_wakeup
);
  // software-visible control state
  logic [7:0] mode_ctrl; // module_mode_control
  logic [7:0] frame_ctrl; // uart_frame_control, bit1 unused here
  logic [7:0] enirq_ctrl; // uart_enable_interrupt_control
  logic single_wire; // uart_single_wire_control bit 0
  logic [7:0] baud_div; // uart_baud_divisor
  // status flags
  logic parity_error_flag;
  logic noise_flag;
  logic framing_error_flag;
  logic overrun_error_flag;
  logic err_clear_armed; // status read seen, next data read clears errors
  // decoded enables
  logic uart_on;
  logic func_on;
  logic tx_on;
  logic rx_on;
  logic ninth_sel;
  logic wr_uart;
  logic rd_data;
  logic wr_data;
  assign uart_on = mode_ctrl[sua_pkg::MODE_SEL_BIT];
  assign func_on = uart_on & frame_ctrl[sua_pkg::FR_FUNC_EN];
  assign tx_on = func_on & enirq_ctrl[sua_pkg::EN_TX];
  assign rx_on = func_on & enirq_ctrl[sua_pkg::EN_RX];
  assign ninth_sel = frame_ctrl[sua_pkg::FR_NINTH_SEL];
  // uart registers only answer while uart mode is selected
  assign wr_uart = reg_req.wr & uart_on;
  assign rd_data = reg_req.rd & uart_on & (reg_req.sel == sua_pkg::SEL_DATA);
  assign wr_data = wr_uart & (reg_req.sel == sua_pkg::SEL_DATA);

  // mode register is always reachable; it owns the uart select
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      mode_ctrl <= sua_pkg::MODE_RST;
    else if (reg_req.wr && reg_req.sel == sua_pkg::SEL_MODE)
      mode_ctrl <= reg_req.wdata;
  end

  // uart control registers; held at power-on values outside uart mode
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      frame_ctrl <= sua_pkg::FRAME_RST;
      enirq_ctrl <= sua_pkg::ENIRQ_RST;
      single_wire <= 1'b0;
      baud_div <= sua_pkg::BAUD_RST;
    end
    else if (!uart_on)
    begin
      frame_ctrl <= sua_pkg::FRAME_RST;
      enirq_ctrl <= sua_pkg::ENIRQ_RST;
      single_wire <= 1'b0;
      baud_div <= sua_pkg::BAUD_RST;
    end
    else if (wr_uart)
    begin
      case (reg_req.sel)
        sua_pkg::SEL_FRAME: frame_ctrl <= reg_req.wdata;
        sua_pkg::SEL_ENIRQ: enirq_ctrl <= reg_req.wdata;
        sua_pkg::SEL_SWIRE:
          single_wire <= reg_req.wdata[sua_pkg::SW_SELECT];
        sua_pkg::SEL_BAUD: baud_div <= reg_req.wdata;
        default: ; // status and data are handled elsewhere
      endcase
    end
  end

  // baud generator: divisor+1 cycles per tick, a further /4 at low speed
  logic [7:0] pre_cnt;
  logic [1:0] slow_cnt;
  logic tick; // sixteen ticks per bit
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_cnt <= sua_pkg::ZERO8;
      slow_cnt <= 2'h0;
      tick <= 1'b0;
    end
    else if (!func_on)
    begin
      pre_cnt <= sua_pkg::ZERO8;
      slow_cnt <= 2'h0;
      tick <= 1'b0;
    end
    else if (pre_cnt == baud_div)
    begin
      pre_cnt <= sua_pkg::ZERO8;
      slow_cnt <= slow_cnt + 2'h1;
      tick <= enirq_ctrl[sua_pkg::EN_SPEED] |
              (slow_cnt == sua_pkg::SLOW_LAST);
    end
    else
    begin
      pre_cnt <= pre_cnt + 8'h01;
      tick <= 1'b0;
    end
  end

  // transmit holding register, loaded by a data write
  logic [7:0] tx_hold;
  logic tx_hold_full;
  logic tx_load; // hold moves into the shift register
  sua_pkg::sua_state_t tx_state;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_hold <= sua_pkg::ZERO8;
      tx_hold_full <= 1'b0;
    end
    else if (!tx_on)
      tx_hold_full <= 1'b0;
    else if (wr_data)
    begin
      // a write while full replaces the waiting byte
      tx_hold <= reg_req.wdata;
      tx_hold_full <= 1'b1;
    end
    else if (tx_load)
      tx_hold_full <= 1'b0;
  end

  // transmit shifter; no address reaches it
  logic [8:0] tx_shift;
  logic [3:0] tx_tick_cnt;
  logic [3:0] tx_bits;
  logic tx_parity;
  logic tx_stop2; // second stop bit still to send
  logic tx_line;
  logic tx_bit_end;
  assign tx_load = tx_on & tx_hold_full & (tx_state == sua_pkg::ST_IDLE);
  assign tx_bit_end = tick & (tx_tick_cnt == sua_pkg::OVS_LAST);
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_state <= sua_pkg::ST_IDLE;
      tx_shift <= 9'h000;
      tx_tick_cnt <= 4'h0;
      tx_bits <= 4'h0;
      tx_parity <= 1'b0;
      tx_stop2 <= 1'b0;
    end
    else if (!tx_on)
      tx_state <= sua_pkg::ST_IDLE;
    else if (tx_load)
    begin
      tx_state <= sua_pkg::ST_START;
      tx_shift <= {frame_ctrl[sua_pkg::FR_TX_NINTH], tx_hold};
      // odd type inverts the even sum
      tx_parity <= (^tx_hold) ^
                   (ninth_sel & frame_ctrl[sua_pkg::FR_TX_NINTH]) ^
                   frame_ctrl[sua_pkg::FR_PAR_TYPE];
      tx_tick_cnt <= 4'h0;
      tx_bits <= 4'h0;
    end
    else if (tick)
    begin
      tx_tick_cnt <= tx_tick_cnt + 4'h1;
      if (tx_bit_end)
      begin
        case (tx_state)
          sua_pkg::ST_START: tx_state <= sua_pkg::ST_DATA;
          sua_pkg::ST_DATA:
          begin
            tx_shift <= {1'b0, tx_shift[8:1]};
            tx_bits <= tx_bits + 4'h1;
            if (tx_bits == (ninth_sel ? sua_pkg::BITS_9 - 4'h1
                                      : sua_pkg::BITS_8 - 4'h1))
            begin
              tx_state <= frame_ctrl[sua_pkg::FR_PAR_EN] ?
                          sua_pkg::ST_PARITY : sua_pkg::ST_STOP;
              tx_stop2 <= frame_ctrl[sua_pkg::FR_STOP_CNT];
            end
          end
          sua_pkg::ST_PARITY: tx_state <= sua_pkg::ST_STOP;
          sua_pkg::ST_STOP:
          begin
            if (tx_stop2)
              tx_stop2 <= 1'b0;
            else
              tx_state <= sua_pkg::ST_IDLE;
          end
          default: tx_state <= sua_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // line level; break holds the line low whatever the shifter does
  always_comb
  begin
    case (tx_state)
      sua_pkg::ST_START: tx_line = 1'b0;
      sua_pkg::ST_DATA: tx_line = tx_shift[0];
      sua_pkg::ST_PARITY: tx_line = tx_parity;
      default: tx_line = 1'b1;
    endcase
    if (frame_ctrl[sua_pkg::FR_BREAK])
      tx_line = 1'b0;
  end

  // receive pin synchroniser, then edge history
  logic rx_sync1;
  logic rx_sync2;
  logic rx_prev;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_sync1 <= 1'b1;
      rx_sync2 <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_sync1 <= serial_in_shared_pin_in;
      rx_sync2 <= rx_sync1;
      rx_prev <= rx_sync2;
    end
  end

  // receive shifter with three-sample majority vote per bit
  sua_pkg::sua_state_t rx_state;
  logic [8:0] rx_shift;
  logic [3:0] rx_tick_cnt;
  logic [3:0] rx_bits;
  logic [2:0] rx_samp;
  logic rx_noise; // disagreement seen in this frame
  logic rx_par_bad;
  logic rx_done; // one-cycle: character complete
  logic rx_frame_bad;
  logic rx_vote;
  logic rx_bit_end;
  assign rx_vote = (rx_samp[0] & rx_samp[1]) | (rx_samp[0] & rx_samp[2]) |
                   (rx_samp[1] & rx_samp[2]);
  // stop ends at its vote so a gapless next start edge is still seen
  assign rx_bit_end = tick & (rx_tick_cnt == (rx_state == sua_pkg::ST_STOP ?
    sua_pkg::SAMPLE_C + 4'h1 : sua_pkg::OVS_LAST));
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_state <= sua_pkg::ST_IDLE;
      rx_shift <= 9'h000;
      rx_tick_cnt <= 4'h0;
      rx_bits <= 4'h0;
      rx_samp <= 3'h7;
      rx_noise <= 1'b0;
      rx_par_bad <= 1'b0;
      rx_done <= 1'b0;
      rx_frame_bad <= 1'b0;
    end
    else if (!rx_on)
    begin
      rx_state <= sua_pkg::ST_IDLE;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (rx_state == sua_pkg::ST_IDLE)
      begin
        if (rx_prev && !rx_sync2)
        begin
          // falling edge starts a frame
          rx_state <= sua_pkg::ST_START;
          rx_tick_cnt <= 4'h0;
          rx_bits <= 4'h0;
          rx_noise <= 1'b0;
          rx_par_bad <= frame_ctrl[sua_pkg::FR_PAR_TYPE];
        end
      end
      else if (tick)
      begin
        rx_tick_cnt <= rx_tick_cnt + 4'h1;
        if (rx_tick_cnt == sua_pkg::SAMPLE_A)
          rx_samp[0] <= rx_sync2;
        if (rx_tick_cnt == sua_pkg::SAMPLE_B)
          rx_samp[1] <= rx_sync2;
        if (rx_tick_cnt == sua_pkg::SAMPLE_C)
          rx_samp[2] <= rx_sync2;
        if (rx_bit_end)
        begin
          if (rx_samp != 3'h0 && rx_samp != 3'h7)
            rx_noise <= 1'b1;
          case (rx_state)
            sua_pkg::ST_START:
              rx_state <= rx_vote ? sua_pkg::ST_IDLE : sua_pkg::ST_DATA;
            sua_pkg::ST_DATA:
            begin
              rx_shift <= {rx_vote, rx_shift[8:1]};
              rx_par_bad <= rx_par_bad ^ rx_vote;
              rx_bits <= rx_bits + 4'h1;
              if (rx_bits == (ninth_sel ? sua_pkg::BITS_9 - 4'h1
                                        : sua_pkg::BITS_8 - 4'h1))
                rx_state <= frame_ctrl[sua_pkg::FR_PAR_EN] ?
                            sua_pkg::ST_PARITY : sua_pkg::ST_STOP;
            end
            sua_pkg::ST_PARITY:
            begin
              rx_par_bad <= rx_par_bad ^ rx_vote;
              rx_state <= sua_pkg::ST_STOP;
            end
            sua_pkg::ST_STOP:
            begin
              rx_frame_bad <= ~rx_vote;
              rx_done <= 1'b1;
              rx_state <= sua_pkg::ST_IDLE;
            end
            default: rx_state <= sua_pkg::ST_IDLE;
          endcase
        end
      end
    end
  end

  // assembled character, aligned for 8 or 9 bits
  sua_pkg::sua_rx_entry_t rx_char;
  always_comb
  begin
    rx_char.ninth = ninth_sel & rx_shift[8];
    rx_char.data = ninth_sel ? rx_shift[7:0] : rx_shift[8:1];
    rx_char.last = ninth_sel ? rx_shift[8] : rx_shift[8];
  end

  // two-entry receive buffer; a full buffer refuses and keeps its data
  sua_pkg::sua_rx_entry_t rx_fifo [2];
  logic rx_wr_ptr;
  logic rx_rd_ptr;
  logic [1:0] rx_count;
  logic rx_full;
  logic rx_push;
  logic rx_pop;
  assign rx_full = (rx_count == sua_pkg::FIFO_DEPTH);
  assign rx_push = rx_done & ~rx_full;
  assign rx_pop = rd_data & (rx_count != 2'h0);
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_fifo[0] <= '0;
      rx_fifo[1] <= '0;
      rx_wr_ptr <= 1'b0;
      rx_rd_ptr <= 1'b0;
      rx_count <= 2'h0;
    end
    else
    begin
      if (rx_push)
      begin
        rx_fifo[rx_wr_ptr] <= rx_char;
        rx_wr_ptr <= ~rx_wr_ptr;
      end
      if (rx_pop)
        rx_rd_ptr <= ~rx_rd_ptr;
      if (rx_push && !rx_pop)
        rx_count <= rx_count + 2'h1;
      else if (rx_pop && !rx_push)
        rx_count <= rx_count - 2'h1;
    end
  end

  // error flags: set by the receiver, cleared by status read then data read
  logic err_clear;
  assign err_clear = rd_data & err_clear_armed;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      parity_error_flag <= 1'b0;
      noise_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
      err_clear_armed <= 1'b0;
    end
    else if (!uart_on)
    begin
      parity_error_flag <= 1'b0;
      noise_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
      err_clear_armed <= 1'b0;
    end
    else
    begin
      if (reg_req.rd && reg_req.sel == sua_pkg::SEL_STATUS)
        err_clear_armed <= 1'b1;
      else if (rd_data)
        err_clear_armed <= 1'b0;
      // a new error in the clearing cycle wins
      parity_error_flag <= (rx_done & rx_par_bad &
                            frame_ctrl[sua_pkg::FR_PAR_EN]) |
                           (parity_error_flag & ~err_clear);
      noise_flag <= (rx_done & rx_noise) |
                    (noise_flag & ~err_clear);
      framing_error_flag <= (rx_done & rx_frame_bad) |
                            (framing_error_flag & ~err_clear);
      overrun_error_flag <= (rx_done & rx_full) |
                            (overrun_error_flag & ~err_clear);
    end
  end

  // status as seen by software
  logic tx_empty;
  logic tx_idle;
  logic rx_idle;
  logic [7:0] status_word;
  sua_pkg::sua_rx_entry_t rx_head;
  assign rx_head = rx_fifo[rx_rd_ptr];
  assign tx_empty = ~tx_hold_full;
  assign tx_idle = ~tx_hold_full & (tx_state == sua_pkg::ST_IDLE);
  assign rx_idle = (rx_state == sua_pkg::ST_IDLE);
  assign status_word = {parity_error_flag, noise_flag, framing_error_flag,
                        overrun_error_flag, rx_idle, rx_count != 2'h0,
                        tx_idle, tx_empty};

  // registered read answer; unmapped selects, and uart selects outside uart mode, read zero
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= sua_pkg::ZERO8;
    else if (reg_req.rd)
    begin
      case (reg_req.sel)
        sua_pkg::SEL_MODE: reg_rdata <= mode_ctrl;
        sua_pkg::SEL_STATUS: reg_rdata <= uart_on ? status_word
                                                  : sua_pkg::ZERO8;
        sua_pkg::SEL_FRAME:
        begin
          reg_rdata <= uart_on ? frame_ctrl : sua_pkg::ZERO8;
          reg_rdata[sua_pkg::FR_RX_NINTH] <= uart_on & rx_head.ninth;
        end
        sua_pkg::SEL_ENIRQ: reg_rdata <= uart_on ? enirq_ctrl
                                                 : sua_pkg::ZERO8;
        sua_pkg::SEL_SWIRE: reg_rdata <= {7'h00, uart_on & single_wire};
        sua_pkg::SEL_DATA: reg_rdata <= uart_on ? rx_head.data
                                                : sua_pkg::ZERO8;
        sua_pkg::SEL_BAUD: reg_rdata <= uart_on ? baud_div
                                                : sua_pkg::ZERO8;
        default: reg_rdata <= sua_pkg::ZERO8;
      endcase
    end
  end

  // pin steering; receiver wins the shared pin in single wire mode
  logic sw_tx; // single wire transmitting
  assign sw_tx = single_wire & tx_on & ~rx_on;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      serial_in_shared_pin_out <= 1'b1;
      serial_in_shared_pin_oe <= 1'b0;
      serial_out_pin <= 1'b1;
      serial_out_pin_oe <= 1'b0;
      tx_pullup_disable <= 1'b0;
    end
    else
    begin
      serial_in_shared_pin_out <= tx_line;
      serial_in_shared_pin_oe <= sw_tx;
      serial_out_pin <= tx_line;
      // dedicated pin drives in full duplex, and mirrors in single wire
      serial_out_pin_oe <= single_wire ? sw_tx : tx_on;
      tx_pullup_disable <= single_wire ? sw_tx : tx_on;
    end
  end

  // merged interrupt request and pin wake-up pulse
  logic rx_irq_cause;
  assign rx_irq_cause = (rx_count != 2'h0) &
                        (~enirq_ctrl[sua_pkg::EN_ADDR] | rx_head.last);
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      usim_irq <= 1'b0;
      pin_wakeup <= 1'b0;
    end
    else
    begin
      usim_irq <= func_on &
                  ((enirq_ctrl[sua_pkg::EN_RX_IRQ] &
                    (rx_irq_cause | overrun_error_flag)) |
                   (enirq_ctrl[sua_pkg::EN_TIDLE_IRQ] & tx_idle) |
                   (enirq_ctrl[sua_pkg::EN_TEMPTY_IRQ] &
                    tx_empty));
      pin_wakeup <= uart_on & enirq_ctrl[sua_pkg::EN_WAKE] &
                    rx_prev & ~rx_sync2;
    end
  end
endmodule

// file: src/sua_pkg.sv
// shared constants and types for the serial module async (uart) function
package sua_pkg;
  // register selects on the cpu data-memory port
  localparam logic [2:0] SEL_MODE = 3'h0;
  localparam logic [2:0] SEL_STATUS = 3'h1;
  localparam logic [2:0] SEL_FRAME = 3'h2;
  localparam logic [2:0] SEL_ENIRQ = 3'h3;
  localparam logic [2:0] SEL_SWIRE = 3'h4;
  localparam logic [2:0] SEL_DATA = 3'h5;
  localparam logic [2:0] SEL_BAUD = 3'h6;
  // module_mode_control fields
  localparam int MODE_SEL_BIT = 4;
  // uart_frame_control fields
  localparam int FR_FUNC_EN = 7;
  localparam int FR_NINTH_SEL = 6;
  localparam int FR_PAR_EN = 5;
  localparam int FR_PAR_TYPE = 4;
  localparam int FR_STOP_CNT = 3;
  localparam int FR_BREAK = 2;
  localparam int FR_RX_NINTH = 1;
  localparam int FR_TX_NINTH = 0;
  // uart_enable_interrupt_control fields
  localparam int EN_TX = 7;
  localparam int EN_RX = 6;
  localparam int EN_SPEED = 5;
  localparam int EN_ADDR = 4;
  localparam int EN_WAKE = 3;
  localparam int EN_RX_IRQ = 2;
  localparam int EN_TIDLE_IRQ = 1;
  localparam int EN_TEMPTY_IRQ = 0;
  // uart_single_wire_control fields
  localparam int SW_SELECT = 0;
  // power-on values
  localparam logic [7:0] MODE_RST = 8'he0;
  localparam logic [7:0] FRAME_RST = 8'h00;
  localparam logic [7:0] ENIRQ_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  // oversampling: sixteen ticks per bit, majority of three mid samples
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  localparam logic [1:0] SLOW_LAST = 2'h3;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  // shift state, shared by both directions
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP = 3'b100
  } sua_state_t;
  // one cpu access
  typedef struct packed {
    logic [2:0] sel;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sua_reg_req_t;
  // one receive buffer entry
  typedef struct packed {
    logic ninth;
    logic last;
    logic [7:0] data;
  } sua_rx_entry_t;
endpackage

// file: tb/sua_uart_checker.sv
// port checker for the async serial function
`timescale 1ns/100ps
module sua_uart_checker (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire sua_pkg::sua_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic serial_in_shared_pin_in,
  input wire logic serial_in_shared_pin_out,
  input wire logic serial_in_shared_pin_oe,
  input wire logic serial_out_pin,
  input wire logic serial_out_pin_oe,
  input wire logic tx_pullup_disable,
  input wire logic usim_irq,
  input wire logic pin_wakeup
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  // shadow of the control bits, plus a one-cycle-late copy
  // because the design's pin and irq outputs are registered
  logic on_q;
  logic sw_q;
  logic sw_d;
  logic [7:0] en_q;
  logic [7:0] en_d;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      on_q <= 1'b0;
      sw_q <= 1'b0;
      sw_d <= 1'b0;
      en_q <= 8'h00;
      en_d <= 8'h00;
    end
    else
    begin
      sw_d <= sw_q;
      en_d <= en_q;
      if (reg_req.wr && reg_req.sel == sua_pkg::SEL_MODE)
        on_q <= reg_req.wdata[sua_pkg::MODE_SEL_BIT];
      // writes are dropped while the uart mode is off
      if (!on_q)
      begin
        sw_q <= 1'b0;
        en_q <= 8'h00;
      end
      else if (reg_req.wr && reg_req.sel == sua_pkg::SEL_ENIRQ)
        en_q <= reg_req.wdata;
      else if (reg_req.wr && reg_req.sel == sua_pkg::SEL_SWIRE)
        sw_q <= reg_req.wdata[0];
    end
  pullup_follows_a: assert property (
    tx_pullup_disable == serial_out_pin_oe) else $error("pull-up mismatch");
  shared_mirror_a: assert property (
    serial_in_shared_pin_oe |-> serial_out_pin_oe &&
    serial_in_shared_pin_out == serial_out_pin) else $error("mirror lost");
  shared_drive_a: assert property (
    serial_in_shared_pin_oe |-> sw_d && en_d[7] && !en_d[6])
    else $error("shared pin driven wrongly");
  rdata_hold_a: assert property (
    !reg_req.rd |=> $stable(reg_rdata)) else $error("rdata moved");
  unmapped_zero_a: assert property (
    reg_req.rd && reg_req.sel == 3'h7 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  gated_read_a: assert property (
    reg_req.rd && !on_q && reg_req.sel != sua_pkg::SEL_MODE
    |=> reg_rdata == 8'h00) else $error("read while mode off");
  wake_cause_a: assert property (
    pin_wakeup |-> en_d[3] && !$past(serial_in_shared_pin_in, 3)
    ##1 !pin_wakeup)
    else $error("stray wakeup");
  irq_cause_a: assert property (
    usim_irq |-> (en_d & 8'h07) != 8'h00) else $error("irq not enabled");
endmodule
bind sua_uart sua_uart_checker chk_i (.sys_clk, .rstn, .reg_req,
  .reg_rdata, .serial_in_shared_pin_in, .serial_in_shared_pin_out,
  .serial_in_shared_pin_oe, .serial_out_pin, .serial_out_pin_oe,
  .tx_pullup_disable, .usim_irq, .pin_wakeup);

// file: tb/sua_peer.sv
// remote serial device: sends and captures whole frames
`timescale 1ns/100ps
module sua_peer #(parameter int BIT_CYC = 32) (
  input wire logic sys_clk,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;
  // bits[0] is the start bit; line returns high afterwards
  task automatic send(input logic [12:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      rx_line = bits[i];
      repeat (BIT_CYC) @(negedge sys_clk);
    end
    rx_line = 1'b1;
  endtask
  // wait for a start edge, then sample each bit at its middle
  task automatic grab(input int n, output logic [12:0] bits);
    int w;
    bits = 13'h1fff;
    w = 0;
    while (tx_line !== 1'b0 && w < 4000)
    begin
      @(negedge sys_clk);
      w++;
    end
    repeat (BIT_CYC / 2) @(negedge sys_clk);
    for (int i = 0; i < n; i++)
    begin
      bits[i] = tx_line;
      repeat (BIT_CYC) @(negedge sys_clk);
    end
  endtask
endmodule

// file: tb/serial_module_uart_function_bench.sv
// self-checking bench for the async serial function
`timescale 1ns/100ps
module serial_module_uart_function_bench;
  localparam int BIT = 32; // divisor 1, fast: 16 ticks of 2 cycles
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  sua_pkg::sua_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic serial_in_shared_pin_out;
  logic serial_in_shared_pin_oe;
  logic serial_out_pin;
  logic serial_out_pin_oe;
  logic usim_irq;
  logic peer_tx;
  logic [7:0] q;
  logic [12:0] f;
  logic [8:0] d;
  logic [8:0] dq [3];
  logic [3:0] c;
  logic [3:0] cfgs [5] = '{4'h0, 4'h5, 4'h6, 4'hf, 4'hc};
  int seed = 70;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  // shared pin resolves from the design's enable; tx pin pulled high
  wire shared = serial_in_shared_pin_oe ? serial_in_shared_pin_out : peer_tx;
  wire ded = serial_out_pin_oe ? serial_out_pin : 1'b1;
  sua_uart dut (.sys_clk, .rstn, .reg_req, .reg_rdata,
    .serial_in_shared_pin_in(shared), .serial_in_shared_pin_out,
    .serial_in_shared_pin_oe, .serial_out_pin, .serial_out_pin_oe,
    .tx_pullup_disable(), .usim_irq, .pin_wakeup());
  sua_peer #(.BIT_CYC(BIT)) peer (.sys_clk, .tx_line(ded), .rx_line(peer_tx));
  // c: [3] nine bits, [2] parity on, [1] odd, [0] two stops
  function automatic logic [12:0] fexp(input logic [8:0] v, logic [3:0] k);
    logic [12:0] r;
    r = 13'h1fff;
    r[0] = 1'b0;
    r[8:1] = v[7:0];
    if (k[3])
      r[9] = v[8];
    if (k[2])
      r[k[3] ? 10 : 9] = (k[3] ? ^v : ^v[7:0]) ^ k[1];
    return r;
  endfunction
  function automatic int flen(input logic [3:0] k);
    return 10 + k[3] + k[2] + k[0];
  endfunction
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one register cycle, driven between falling edges
  task automatic acc(input logic w, logic [2:0] s, logic [7:0] v,
                     output logic [7:0] r);
    reg_req = '{sel: s, wr: w, rd: !w, wdata: v};
    @(negedge sys_clk);
    r = reg_rdata;
    reg_req = '0;
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] v);
    logic [7:0] r;
    acc(1'b1, s, v, r);
  endtask
  task automatic rd(input logic [2:0] s, output logic [7:0] r);
    acc(1'b0, s, 8'h00, r);
  endtask
  task automatic wait_rx(output logic [7:0] s);
    s = 8'h00;
    for (int k = 0; k < 60 && s[2] !== 1'b1; k++)
      rd(sua_pkg::SEL_STATUS, s);
  endtask
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, well above the few thousand cycles the tests need
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      close_out();
    end
  end
  initial
  begin
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    rd(sua_pkg::SEL_MODE, q);
    chk(q, sua_pkg::MODE_RST);
    wr(sua_pkg::SEL_BAUD, 8'h5a);
    rd(sua_pkg::SEL_BAUD, q);
    chk(q, 8'h00);
    rd(3'h7, q);
    chk(q, 8'h00);
    wr(sua_pkg::SEL_MODE, 8'hf0);
    wr(sua_pkg::SEL_BAUD, 8'h01);
    rd(sua_pkg::SEL_BAUD, q);
    chk(q, 8'h01);
    wr(sua_pkg::SEL_ENIRQ, 8'he8); // tx, rx, fast, wake
    chk(serial_out_pin_oe, 1'b0);
    $display("test gating done");
    for (int i = 0; i < 5; i++)
    begin
      c = cfgs[i];
      d = 9'($random(seed));
      wr(sua_pkg::SEL_FRAME, {1'b1, c, 2'b00, d[8]});
      chk(serial_out_pin_oe, 1'b1);
      wr(sua_pkg::SEL_DATA, d[7:0]);
      peer.grab(flen(c), f);
      chk(f, fexp(d, c));
      d = 9'($random(seed));
      peer.send(fexp(d, c), flen(c));
      wait_rx(q);
      rd(sua_pkg::SEL_FRAME, q);
      if (c[3])
        chk(q[1], d[8]);
      rd(sua_pkg::SEL_DATA, q);
      chk(q, d[7:0]);
    end
    $display("test frames done");
    wr(sua_pkg::SEL_FRAME, 8'ha0); // even parity, bit 9 then stop flipped
    for (int i = 0; i < 2; i++)
    begin
      d = 9'($random(seed));
      peer.send(fexp(d, 4'h4) ^ (13'h0200 << i), 11);
      wait_rx(q);
      chk(q[7:5], i ? 3'b001 : 3'b100);
      rd(sua_pkg::SEL_DATA, q);
    end
    wr(sua_pkg::SEL_FRAME, 8'h80);
    wr(sua_pkg::SEL_ENIRQ, 8'he4);
    for (int i = 0; i < 3; i++)
    begin
      dq[i] = 9'($random(seed));
      peer.send(fexp(dq[i], 4'h0), 10);
    end
    wait_rx(q);
    chk(q[4], 1'b1);
    chk(usim_irq, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      rd(sua_pkg::SEL_DATA, q);
      chk(q, dq[i][7:0]);
    end
    rd(sua_pkg::SEL_STATUS, q);
    chk(q[2], 1'b0);
    wr(sua_pkg::SEL_ENIRQ, 8'hf4);
    for (int i = 0; i < 2; i++)
    begin
      d = i ? 9'h0b5 : 9'h035;
      peer.send(fexp(d, 4'h0), 10);
      wait_rx(q);
      chk(usim_irq, d[7]);
      rd(sua_pkg::SEL_DATA, q);
    end
    $display("test errors done");
    wr(sua_pkg::SEL_SWIRE, 8'h01);
    wr(sua_pkg::SEL_ENIRQ, 8'ha0);
    chk(serial_in_shared_pin_oe, 1'b1);
    d = 9'($random(seed));
    wr(sua_pkg::SEL_DATA, d[7:0]);
    peer.grab(10, f);
    chk(f, fexp(d, 4'h0));
    wr(sua_pkg::SEL_ENIRQ, 8'he0);
    chk(serial_in_shared_pin_oe, 1'b0);
    wr(sua_pkg::SEL_FRAME, 8'h84); // break holds the line low
    chk(serial_out_pin, 1'b0);
    wr(sua_pkg::SEL_ENIRQ, 8'h82);
    chk(usim_irq, 1'b1);
    $display("test single wire done");
    close_out();
  end
endmodule
